// ---- hdl/afc_host.sv ----
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ns
module afc_host (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic [3:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [31:0] rdata,
  output logic            write_n,
  output logic            read_n,
  output logic            init_in_n,
  output logic            lead_replay_src_sel_n,
  output logic      [8:0] data_in,
  input  wire logic [8:0] q_in,
  output logic      [8:0] q_out,
  output logic            q_oe,
  input  wire logic       empty_ind_n,
  input  wire logic       full_ind_n,
  input  wire logic       third_ind_n
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_ASSERT = 3'b001, ST_WAIT = 3'b011, ST_RECOVER = 3'b010,
    ST_INIT = 3'b110, ST_LREAD = 3'b111, ST_LWR = 3'b101, ST_LGAP = 3'b100
  } afc_state_t;
  typedef struct packed {
    afc_state_t  st;
    logic        is_read;
    logic        phase;
    logic [7:0]  cnt;
    logic [8:0]  wdat;
    logic [8:0]  rdat;
    logic        rvalid;
    logic [8:0]  nf_cfg;
    logic [8:0]  ne_cfg;
    logic        srcsel;
    logic        lead_n;
    logic        done;
    logic [31:0] rdata;
  } afc_host_state_t;
  afc_host_state_t cur_ff;
  afc_host_state_t nxt_s;
  logic            busy;
  logic            cmd_wr;
  logic            cmd_rd;
  logic            cmd_ld;
  logic            cmd_init;
  logic            write_ok;
  logic            read_ok;
  assign busy   = (cur_ff.st != ST_IDLE);
  assign cmd_wr = wr_stb && addr == afc_pkg::ADDR_CTRL && wdata[afc_pkg::CTRL_WRITE_BIT];
  assign cmd_rd = wr_stb && addr == afc_pkg::ADDR_CTRL && wdata[afc_pkg::CTRL_READ_BIT];
  assign cmd_ld = wr_stb && addr == afc_pkg::ADDR_CTRL && wdata[afc_pkg::CTRL_LOAD_BIT];
  assign cmd_init = wr_stb && addr == afc_pkg::ADDR_CTRL && wdata[afc_pkg::CTRL_INIT_BIT];
  assign write_ok = full_ind_n;
  assign read_ok  = empty_ind_n;
  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_s = cur_ff;
    nxt_s.done = 1'b0;
    nxt_s.rdata = 32'h0000_0000;
    if (wr_stb && !busy) begin
      unique case (addr)
        afc_pkg::ADDR_WDATA: nxt_s.wdat = wdata[8:0];
        // reserved offset bits kept zero on the way out
        afc_pkg::ADDR_NF_CFG: nxt_s.nf_cfg = {wdata[8], 2'b00, wdata[5:0]};
        afc_pkg::ADDR_NE_CFG: nxt_s.ne_cfg = {wdata[8], 2'b00, wdata[5:0]};
        afc_pkg::ADDR_TIMING: begin
          nxt_s.srcsel = wdata[afc_pkg::CTRL_SRCSEL_BIT];
          nxt_s.lead_n = wdata[0];
        end
        default: ;
      endcase
    end
    if (rd_stb) begin
      unique case (addr)
        afc_pkg::ADDR_STATUS: nxt_s.rdata = {24'h00_0000, cur_ff.rvalid, busy,
          3'b000, third_ind_n, full_ind_n, empty_ind_n};
        afc_pkg::ADDR_RDATA: nxt_s.rdata = {23'h00_0000, cur_ff.rdat};
        afc_pkg::ADDR_NF_CFG: nxt_s.rdata = {23'h00_0000, cur_ff.nf_cfg};
        afc_pkg::ADDR_NE_CFG: nxt_s.rdata = {23'h00_0000, cur_ff.ne_cfg};
        default: nxt_s.rdata = 32'h0000_0000;
      endcase
      if (addr == afc_pkg::ADDR_RDATA) nxt_s.rvalid = 1'b0;
    end
    unique case (cur_ff.st)
      ST_IDLE: begin
        nxt_s.cnt = 8'h00;
        // a strobe may be held on a full or empty buffer; it completes after the
        // opposite strobe rises and the indicator goes high
        if (cmd_ld) begin
          nxt_s.st = ST_INIT;
          nxt_s.phase = 1'b0;
        end else if (cmd_init) begin
          nxt_s.st = ST_INIT;
          nxt_s.phase = 1'b1;
        end else if (cmd_wr) begin
          nxt_s.st = ST_ASSERT;
          nxt_s.is_read = 1'b0;
        end else if (cmd_rd) begin
          nxt_s.st = ST_ASSERT;
          nxt_s.is_read = 1'b1;
        end
      end
      ST_ASSERT: begin
        // hold strobe until the buffer can take the access
        if (cur_ff.is_read ? read_ok : write_ok) begin
          nxt_s.st = ST_WAIT;
          nxt_s.cnt = 8'h00;
        end
      end
      ST_WAIT: begin
        nxt_s.cnt = cur_ff.cnt + 8'h01;
        if (cur_ff.cnt == 8'(afc_pkg::STROBE_CYC - 1)) begin
          nxt_s.st = ST_RECOVER;
          nxt_s.cnt = 8'h00;
          if (cur_ff.is_read) begin
            nxt_s.rdat = q_in;
            nxt_s.rvalid = 1'b1;
          end
        end
      end
      ST_RECOVER: begin
        nxt_s.cnt = cur_ff.cnt + 8'h01;
        if (cur_ff.cnt == 8'(afc_pkg::RECOVER_CYC - 1)) begin
          nxt_s.st = ST_IDLE;
          nxt_s.done = 1'b1;
        end
      end
      ST_INIT: begin
        nxt_s.cnt = cur_ff.cnt + 8'h01;
        if (!cur_ff.phase && cur_ff.cnt == 8'(afc_pkg::INIT_TO_READ_CYC - 1)) begin
          nxt_s.st = ST_LREAD;
          nxt_s.cnt = 8'h00;
        end else if (cur_ff.phase && cur_ff.cnt == 8'(afc_pkg::INIT_PULSE_CYC - 1)) begin
          nxt_s.st = ST_RECOVER;
          nxt_s.cnt = 8'h00;
        end
      end
      ST_LREAD: begin
        nxt_s.cnt = cur_ff.cnt + 8'h01;
        if (cur_ff.cnt == 8'(afc_pkg::INIT_TO_READ_CYC - 1)) begin
          nxt_s.st = ST_LWR;
          nxt_s.cnt = 8'h00;
        end
      end
      ST_LWR: begin
        nxt_s.cnt = cur_ff.cnt + 8'h01;
        if (cur_ff.cnt == 8'(afc_pkg::STROBE_CYC - 1)) begin
          nxt_s.st = ST_LGAP;
          nxt_s.cnt = 8'h00;
        end
      end
      ST_LGAP: begin
        nxt_s.cnt = cur_ff.cnt + 8'h01;
        if (cur_ff.cnt == 8'(afc_pkg::RECOVER_CYC - 1)) begin
          nxt_s.cnt = 8'h00;
          // near-full goes first, near-empty second
          if (!cur_ff.phase) begin
            nxt_s.phase = 1'b1;
            nxt_s.st = ST_LWR;
          end else begin
            nxt_s.st = ST_IDLE;
            nxt_s.done = 1'b1;
          end
        end
      end
      default: nxt_s.st = ST_IDLE;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cur_ff <= '{st: ST_IDLE, is_read: 1'b0, phase: 1'b0, cnt: 8'h00, wdat: 9'h000,
                 rdat: 9'h000, rvalid: 1'b0, nf_cfg: afc_pkg::NF_RESET,
                 ne_cfg: afc_pkg::NE_RESET, srcsel: 1'b0, lead_n: 1'b0,
                 done: 1'b0, rdata: 32'h0000_0000};
    end else begin
      cur_ff <= nxt_s;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  logic load_st;
  assign load_st   = cur_ff.st inside {ST_LREAD, ST_LWR, ST_LGAP};
  assign rdata     = cur_ff.rdata;
  assign init_in_n = !(cur_ff.st == ST_INIT || load_st);
  // read strobe goes low the init-to-read delay after init, and stays low to the end
  assign read_n    = !((cur_ff.st inside {ST_ASSERT, ST_WAIT} && cur_ff.is_read)
                       || load_st);
  assign write_n   = !((cur_ff.st inside {ST_ASSERT, ST_WAIT} && !cur_ff.is_read)
                       || cur_ff.st == ST_LWR);
  // during a load the same pin selects where the threshold data comes from
  assign lead_replay_src_sel_n = load_st ? cur_ff.srcsel : cur_ff.lead_n;
  assign data_in   = (load_st && !cur_ff.srcsel) ?
                     (cur_ff.phase ? cur_ff.ne_cfg : cur_ff.nf_cfg) : cur_ff.wdat;
  assign q_out     = cur_ff.phase ? cur_ff.ne_cfg : cur_ff.nf_cfg;
  assign q_oe      = load_st && cur_ff.srcsel;
  ////////////////////////////////////////////////////////////////////////////////
  chk_load_order: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cur_ff.st == ST_LGAP && !cur_ff.phase && cur_ff.cnt == 8'(afc_pkg::RECOVER_CYC - 1)
    |=> cur_ff.st == ST_LWR && cur_ff.phase)
    else $error("second load write not issued");
  chk_init_delay: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $fell(init_in_n) && cur_ff.st == ST_INIT && !cur_ff.phase
    |-> read_n [*3])
    else $error("read strobe too soon after init");
  chk_write_full: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cur_ff.st == ST_ASSERT && !cur_ff.is_read && !full_ind_n |=> !write_n)
    else $error("write strobe released while full");
  chk_read_empty: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cur_ff.st == ST_ASSERT && cur_ff.is_read && !empty_ind_n |=> cur_ff.st == ST_ASSERT)
    else $error("read completed while empty");
  chk_strobe_excl: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !write_n && !read_n |-> !init_in_n)
    else $error("both strobes low outside load");
  chk_src_drive: assert property (@(posedge clk_sys) disable iff (!reset_n)
    q_oe |-> !init_in_n && lead_replay_src_sel_n)
    else $error("output pins driven outside load");
  chk_rsvd_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
    load_st |-> (cur_ff.srcsel ? q_out[7:6] : data_in[7:6]) == 2'b00)
    else $error("reserved threshold bits set");
  chk_read_done: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cur_ff.st == ST_WAIT && cur_ff.is_read && cur_ff.cnt == 8'(afc_pkg::STROBE_CYC - 1)
    |=> cur_ff.rvalid && cur_ff.st == ST_RECOVER)
    else $error("read data not captured");
  ////////////////////////////////////////////////////////////////////////////////
  chk_init_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cur_ff.st == ST_INIT
    |-> read_n && write_n && !init_in_n)
    else $error("strobe low during init pulse");

  chk_init_width: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $fell(init_in_n) && cur_ff.phase
    |-> (!init_in_n) [*6])
    else $error("init pulse too short");

  chk_init_end: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cur_ff.st == ST_INIT && cur_ff.phase && cur_ff.cnt == 8'(afc_pkg::INIT_PULSE_CYC - 1)
    |=> init_in_n && cur_ff.st == ST_RECOVER)
    else $error("init pulse not released");

  chk_load_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cur_ff.st == ST_INIT && !cur_ff.phase && cur_ff.cnt == 8'(afc_pkg::INIT_TO_READ_CYC - 1)
    |=> !read_n && !init_in_n && write_n)
    else $error("load read strobe not issued");

  chk_load_lead: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cur_ff.st == ST_LREAD
    |-> !read_n && write_n)
    else $error("load lead-in strobes wrong");

  chk_load_pulse: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $fell(write_n) && load_st
    |-> (!write_n) [*4] ##1 write_n)
    else $error("load write pulse width wrong");

  chk_load_gap: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cur_ff.st == ST_LGAP
    |-> write_n && !read_n && !init_in_n)
    else $error("load gap strobes wrong");

  chk_load_data: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !write_n && !$past(write_n) && load_st
    |-> $stable(data_in) && $stable(q_out))
    else $error("load data moved under strobe");

  chk_load_close: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cur_ff.st == ST_LGAP && cur_ff.phase && cur_ff.cnt == 8'(afc_pkg::RECOVER_CYC - 1)
    |=> init_in_n && read_n && write_n)
    else $error("load not closed");

  chk_load_source: assert property (@(posedge clk_sys) disable iff (!reset_n)
    load_st && !cur_ff.srcsel
    |-> !q_oe && data_in == (cur_ff.phase ? cur_ff.ne_cfg : cur_ff.nf_cfg))
    else $error("input pins not carrying threshold");

  chk_oe_value: assert property (@(posedge clk_sys) disable iff (!reset_n)
    q_oe
    |-> q_out == (cur_ff.phase ? cur_ff.ne_cfg : cur_ff.nf_cfg))
    else $error("output pins not carrying threshold");

  chk_one_strobe: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cur_ff.st inside {ST_ASSERT, ST_WAIT}
    |-> init_in_n && (write_n != read_n))
    else $error("access strobes not exclusive");

  chk_strobe_width: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cur_ff.st == ST_ASSERT && (cur_ff.is_read ? read_ok : write_ok)
    |=> (cur_ff.st == ST_WAIT) [*4] ##1 cur_ff.st == ST_RECOVER)
    else $error("access strobe width wrong");

  chk_recover_high: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cur_ff.st == ST_RECOVER
    |-> write_n && read_n && init_in_n)
    else $error("strobe low in recovery");

  chk_recover_len: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cur_ff.st == ST_RECOVER && cur_ff.cnt == 8'(afc_pkg::RECOVER_CYC - 1)
    |=> !busy)
    else $error("recovery overran");

  chk_read_capture: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cur_ff.st == ST_WAIT && cur_ff.is_read && cur_ff.cnt == 8'(afc_pkg::STROBE_CYC - 1)
    |=> cur_ff.rdat == $past(q_in))
    else $error("read word not the pin value");

  chk_write_data: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !write_n && !load_st
    |-> data_in == cur_ff.wdat)
    else $error("write data not on pins");

  chk_read_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cur_ff.st == ST_ASSERT && cur_ff.is_read
    |-> !read_n && write_n)
    else $error("pending read strobe not held");

  chk_write_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cur_ff.st == ST_ASSERT && !cur_ff.is_read
    |-> !write_n && read_n)
    else $error("pending write strobe not held");

  chk_lead_level: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !load_st
    |-> lead_replay_src_sel_n == cur_ff.lead_n)
    else $error("lead select not shown");

  chk_rsvd_regs: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cur_ff.nf_cfg[7:6] == 2'b00
    && cur_ff.ne_cfg[7:6] == 2'b00)
    else $error("reserved bits held in config");

  chk_status_live: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $past(rd_stb) && $past(addr) == afc_pkg::ADDR_STATUS
    |-> rdata[2:0] == {$past(third_ind_n), $past(full_ind_n), $past(empty_ind_n)}
        && rdata[6] == $past(busy))
    else $error("status word not live");

  chk_rdata_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !$past(rd_stb)
    |-> rdata == 32'h0000_0000)
    else $error("read data outside answer cycle");

  chk_rvalid_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $past(rd_stb) && $past(addr) == afc_pkg::ADDR_RDATA && $past(cur_ff.st) != ST_WAIT
    |-> !cur_ff.rvalid)
    else $error("read valid not cleared");

  chk_cmd_take: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !busy && cmd_wr && !wdata[afc_pkg::CTRL_LOAD_BIT] && !wdata[afc_pkg::CTRL_INIT_BIT]
    |=> cur_ff.st == ST_ASSERT && !write_n)
    else $error("write command not started");
endmodule // afc_host

// ---- hdl/afc_pkg.sv ----
package afc_pkg;
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_STATUS   = 4'h1;
  localparam logic [3:0] ADDR_WDATA    = 4'h2;
  localparam logic [3:0] ADDR_RDATA    = 4'h3;
  localparam logic [3:0] ADDR_NF_CFG   = 4'h4;
  localparam logic [3:0] ADDR_NE_CFG   = 4'h5;
  localparam logic [3:0] ADDR_TIMING   = 4'h6;
  localparam int CTRL_WRITE_BIT  = 0;
  localparam int CTRL_READ_BIT   = 1;
  localparam int CTRL_LOAD_BIT   = 2;
  localparam int CTRL_INIT_BIT   = 3;
  localparam int CTRL_SRCSEL_BIT = 4;
  localparam int CFG_MODE_BIT    = 8;
  localparam int CFG_RSVD_LO     = 6;
  localparam int CFG_RSVD_HI     = 7;
  localparam int CLK_MHZ         = 100;
  localparam int INIT_TO_READ_NS = 30;
  localparam int INIT_TO_READ_CYC = (INIT_TO_READ_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_NS       = 40;
  localparam int STROBE_CYC      = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int RECOVER_NS      = 20;
  localparam int RECOVER_CYC     = (RECOVER_NS * CLK_MHZ + 999) / 1000;
  localparam int INIT_PULSE_NS   = 60;
  localparam int INIT_PULSE_CYC  = (INIT_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [8:0] NF_RESET = 9'h000;
  localparam logic [8:0] NE_RESET = 9'h000;
endpackage

// ---- test/afc_fifo_model.sv ----
`timescale 1ns/1ns
module afc_fifo_model #(
  parameter int DEPTH = 8
) (
  input  wire logic       write_n,
  input  wire logic       read_n,
  input  wire logic       init_in_n,
  input  wire logic       src_sel_n,
  input  wire logic [8:0] data_in,
  input  wire logic [8:0] q_drv,
  output logic      [8:0] q,
  output logic            empty_ind_n,
  output logic            full_ind_n,
  output logic            third_ind_n
);
  logic [8:0] mem [DEPTH];
  logic [8:0] nf_cfg = 9'h000;
  logic [8:0] ne_cfg = 9'h000;
  logic [8:0] last_q = 9'h000;
  int         cnt = 0;
  int         rp = 0;
  int         wp = 0;
  bit         cfg_on = 0;
  bit         loading = 0;
  bit         second = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // released pins show the inverse of the last word
  assign q = (!read_n && cnt > 0 && !loading) ? mem[rp] : ~last_q;
  always @(negedge init_in_n) begin
    if (!ne_cfg[8]) begin
      cnt = 0;
      rp = 0;
      wp = 0;
      cfg_on = 0;
      nf_cfg = 9'h000;
      ne_cfg = 9'h000;
    end
  end
  always @(negedge read_n) begin
    if (!init_in_n) begin
      loading = 1;
      second = 0;
    end
  end
  always @(posedge read_n) begin
    if (loading) begin
      loading = 0;
    end else if (cnt > 0) begin
      last_q = mem[rp];
      rp = (rp + 1) % DEPTH;
      cnt--;
    end
  end
  always @(posedge write_n) begin
    if (loading) begin
      if (!second) nf_cfg = src_sel_n ? q_drv : data_in;
      else ne_cfg = src_sel_n ? q_drv : data_in;
      second = 1;
      cfg_on = 1;
    end else if (cnt < DEPTH) begin
      mem[wp] = data_in;
      wp = (wp + 1) % DEPTH;
      cnt++;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    full_ind_n = cnt != DEPTH;
    empty_ind_n = cnt != 0;
    third_ind_n = !(cnt > DEPTH / 2);
    if (cfg_on) begin
      empty_ind_n = !(cnt < 2 * int'(ne_cfg[7:0]));
      full_ind_n = !(DEPTH - cnt < 2 * int'(nf_cfg[7:0]));
      if (nf_cfg[8]) third_ind_n = cnt != 0 && cnt != DEPTH;
    end
  end
endmodule // afc_fifo_model

// ---- test/async_fifo_flags_and_expansion_tb_top.sv ----
`timescale 1ns/1ns
module async_fifo_flags_and_expansion_tb_top;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic [31:0] rdata;
  logic        write_n, read_n, init_in_n, sel_n, q_oe;
  logic [8:0]  data_in, q_in, q_out;
  logic        empty_n, full_n, third_n;
  int          n_fail = 0;
  int          total_checks = 0;
  int          wseq = 0;
  int          i;
  logic [31:0] v;
  ////////////////////////////////////////////////////////////////////////////////
  afc_host uut (.clk_sys(clk_sys), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .write_n(write_n), .read_n(read_n),
    .init_in_n(init_in_n), .lead_replay_src_sel_n(sel_n), .data_in(data_in), .q_in(q_in),
    .q_out(q_out), .q_oe(q_oe), .empty_ind_n(empty_n), .full_ind_n(full_n),
    .third_ind_n(third_n));
  afc_fifo_model #(.DEPTH(8)) m (.write_n(write_n), .read_n(read_n), .init_in_n(init_in_n),
    .src_sel_n(sel_n), .data_in(data_in), .q_drv(q_out), .q(q_in), .empty_ind_n(empty_n),
    .full_ind_n(full_n), .third_ind_n(third_n));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic cmd(input logic [31:0] c);
    logic [31:0] s;
    int k;
    reg_wr(afc_pkg::ADDR_CTRL, c);
    s = 32'h40;
    for (k = 0; k < 60 && s[6] !== 1'b0; k++) reg_rd(afc_pkg::ADDR_STATUS, s);
    if (s[6] !== 1'b0) chk(s, 32'h0);
  endtask
  task automatic st(input logic [31:0] e);
    logic [31:0] s;
    reg_rd(afc_pkg::ADDR_STATUS, s);
    chk(s & 32'h7, e);
  endtask
  task automatic put(input int n);
    int k;
    for (k = 0; k < n; k++) begin
      reg_wr(afc_pkg::ADDR_WDATA, 32'h100 + wseq);
      wseq++;
      cmd(32'h1);
    end
  endtask
  task automatic load(input logic [31:0] nf, input logic [31:0] ne, input logic [31:0] t);
    reg_wr(afc_pkg::ADDR_TIMING, t);
    reg_wr(afc_pkg::ADDR_NF_CFG, nf);
    reg_wr(afc_pkg::ADDR_NE_CFG, ne);
    cmd(32'h4);
  endtask
  task automatic conclude();
    $display("checks=%0d failures=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_fail++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    cmd(32'h8);
    st(32'h6);
    reg_rd(4'hf, v);
    put(4);
    st(32'h7);
    put(1);
    st(32'h3);
    put(3);
    st(32'h1);
    for (i = 0; i < 8; i++) begin
      cmd(32'h2);
      reg_rd(afc_pkg::ADDR_RDATA, v);
      chk(v & 32'h1ff, 32'h100 + i);
      if (i == 0) st(32'h3);
    end
    st(32'h6);
    load(32'h1c1, 32'h002, 32'h0);
    chk({14'h0, m.ne_cfg, m.nf_cfg}, {14'h0, 9'h002, 9'h101});
    st(32'h2);
    put(3);
    st(32'h6);
    put(1);
    st(32'h7);
    put(3);
    st(32'h5);
    load(32'h003, 32'h104, 32'h10);
    chk({14'h0, m.ne_cfg, m.nf_cfg}, {14'h0, 9'h104, 9'h003});
    chk(m.cnt, 32'h0);
    put(2);
    cmd(32'h8);
    chk(m.cnt, 32'h2);
    load(32'h003, 32'h004, 32'h0);
    chk({14'h0, m.ne_cfg, m.cnt[8:0]}, {14'h0, 9'h004, 9'h002});
    cmd(32'h8);
    chk(m.cnt, 32'h0);
    conclude();
  end
endmodule // async_fifo_flags_and_expansion_tb_top
